// [logic/triggered_input_logger.sv]
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
`include "logger_map.svh"
module triggered_input_logger
  import logger_pkg::*;
#(
  parameter int BOARDS = 6,
  parameter int BITS = 8,
  parameter logic [15:0] SAMPLE_CYC = 16'(`SAMPLE_CYC)
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // boards
  input wire logic [BOARDS*BITS-1:0] board_input_bits,
  output logic [2:0] base_board_reset_n,
  output logic ext_board_reset_n,
  output logic [BOARDS*BITS-1:0] board_output_bits,
  output logic [BOARDS-1:0] board_output_clock,
  // record write port
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output logic [1:0] mem_wr_cs,
  output logic [27:0] mem_wr_addr,
  output logic [511:0] mem_wr_data,
  // interrupts
  output logic [2:0] host_interrupt_lines,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic pick(input logic [BITS-1:0] bits,
                                input logic [7:0] idx);
    pick = 1'b0;
    for (int i = 0; i < BITS; i++) begin
      if (idx == 8'(i + 1)) begin
        pick = bits[i];
      end
    end
  endfunction : pick
  function automatic reg16_t state_code(input log_state_t s);
    unique case (s)
      S_IDLE: state_code = `ST_IDLE;
      S_PRE: state_code = `ST_PRE;
      S_POST: state_code = `ST_POST;
      S_DONE: state_code = `ST_DONE;
    endcase
  endfunction : state_code
  ////////////////////////////////////////////////////////////////////////
  // state
  logic d_sel;
  logic d_write;
  logic [31:0] d_addr;
  reg16_t run_ctrl;
  reg16_t xfer_ctrl;
  reg16_t trig_pend;
  reg16_t trig_act;
  reg16_t trig_sel;
  reg16_t post_lo;
  reg16_t post_hi;
  reg16_t area;
  reg16_t sys_flag;
  reg16_t qsel_pend [BOARDS];
  reg16_t qsel_act [BOARDS];
  logic sys_run;
  logic trig_prev;
  logic [1:0] int_stat;
  logic [1:0] int_en;
  log_state_t state;
  logic [15:0] tick_cnt;
  logic sample_due;
  logic [31:0] post_left;
  logic [31:0] sample_cnt;
  logic [21:0] rec_idx;
  logic [BOARDS*BITS-1:0] in_sync;
  logic [31:0] qcount [BOARDS];
  logic [BOARDS-1:0] qa;
  logic [BOARDS-1:0] qb;
  logic [16*BOARDS-1:0] qsel_act_flat;
  logic [31:0] next_hrdata;
  logic next_d_sel;
  logic next_d_write;
  logic [31:0] next_d_addr;
  reg16_t next_run_ctrl, next_xfer_ctrl, next_trig_pend, next_trig_act;
  reg16_t next_trig_sel, next_post_lo, next_post_hi, next_area;
  reg16_t next_sys_flag;
  reg16_t next_qsel_pend [BOARDS];
  reg16_t next_qsel_act [BOARDS];
  logic next_sys_run, next_irq;
  logic [1:0] next_int_stat, next_int_en, int_set;
  log_state_t next_state;
  logic [15:0] next_tick_cnt;
  logic next_sample_due, next_mem_wr_valid;
  logic [31:0] next_post_left, next_sample_cnt;
  logic [21:0] next_rec_idx, rec_limit;
  logic [27:0] next_mem_wr_addr;
  logic [511:0] next_mem_wr_data;
  logic [2:0] next_host;
  logic wr_en, xfer_go, trig_edge, trig_take, issue, log_go;
  ////////////////////////////////////////////////////////////////////////
  // pins and counters
  pin_sync #(.W(BOARDS*BITS)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(board_input_bits),
    .sync(in_sync)
  );
  for (genvar b = 0; b < BOARDS; b++) begin : g_cnt
    assign qa[b] = pick(in_sync[b*BITS +: BITS], qsel_act[b][7:0]);
    assign qb[b] = pick(in_sync[b*BITS +: BITS], qsel_act[b][15:8]);
    assign qsel_act_flat[16*b +: 16] = qsel_act[b];
    quad_counter u_cnt (
      .hclk(hclk),
      .hresetn(hresetn),
      .clear(!sys_run),
      .phase_a(qa[b]),
      .phase_b(qb[b]),
      .count(qcount[b])
    );
  end
  ////////////////////////////////////////////////////////////////////////
  // bus, registers and logging
  assign wr_en = d_sel && d_write;
  assign xfer_go = wr_en && d_addr == `A_XFER_CTRL && hwdata[`B_XFER];
  assign trig_edge = trig_act[`B_USER_TRIG] && !trig_prev;
  assign trig_take = trig_edge && trig_sel == `TRIG_SEL_USER
    && state == S_PRE;
  assign log_go = wr_en && d_addr == `A_RUN_CTRL && hwdata[`B_LOG_START]
    && sys_run && state != S_PRE && state != S_POST;
  assign issue = sample_due && (!mem_wr_valid || mem_wr_ready)
    && (state == S_PRE || (state == S_POST && post_left != 32'h0));
  assign rec_limit = {area[12:0], 9'h000};
  always_comb begin
    next_d_sel = d_sel;
    next_d_write = d_write;
    next_d_addr = d_addr;
    next_hrdata = 32'h0000_0000;
    if (hready) begin
      next_d_sel = hsel && htrans[1];
      next_d_write = hwrite;
      next_d_addr = haddr;
      if (hsel && htrans[1] && !hwrite) begin
        unique case (haddr)
          `A_RUN_CTRL: next_hrdata = {16'h0000, run_ctrl};
          `A_XFER_CTRL: next_hrdata = {16'h0000, xfer_ctrl};
          `A_TRIG_CTRL: next_hrdata = {16'h0000, trig_pend};
          `A_SYS_CTRL: next_hrdata = {31'h0, sys_run};
          `A_TRIG_SEL: next_hrdata = {16'h0000, trig_sel};
          `A_POST_LO: next_hrdata = {16'h0000, post_lo};
          `A_POST_HI: next_hrdata = {16'h0000, post_hi};
          `A_AREA: next_hrdata = {16'h0000, area};
          `A_STATE: next_hrdata = {16'h0000, state_code(state)};
          `A_SYS_FLAG: next_hrdata = {16'h0000, sys_flag};
          `A_CNT_LO: next_hrdata = {16'h0000, sample_cnt[15:0]};
          `A_CNT_HI: next_hrdata = {16'h0000, sample_cnt[31:16]};
          `A_INT_STAT: next_hrdata = {30'h0, int_stat};
          `A_INT_EN: next_hrdata = {30'h0, int_en};
          default: begin
            for (int b = 0; b < BOARDS; b++) begin
              if (haddr == `A_QSEL0 + 32'(4 * b)) begin
                next_hrdata = {16'h0000, qsel_pend[b]};
              end
              if (haddr == `A_QVAL0 + 32'(4 * b)) begin
                next_hrdata = qcount[b];
              end
            end
          end
        endcase
      end
    end
    next_run_ctrl = run_ctrl;
    next_xfer_ctrl = xfer_ctrl;
    next_trig_pend = trig_pend;
    next_trig_sel = trig_sel;
    next_post_lo = post_lo;
    next_post_hi = post_hi;
    next_area = area;
    next_sys_run = sys_run;
    next_int_en = int_en;
    next_qsel_pend = qsel_pend;
    int_set = 2'b00;
    if (wr_en) begin
      unique case (d_addr)
        `A_RUN_CTRL: next_run_ctrl = hwdata[15:0];
        `A_XFER_CTRL: next_xfer_ctrl = hwdata[15:0];
        `A_TRIG_CTRL: next_trig_pend = hwdata[15:0];
        `A_SYS_CTRL: next_sys_run = hwdata[`B_RUN];
        `A_TRIG_SEL: next_trig_sel = hwdata[15:0];
        `A_POST_LO: next_post_lo = hwdata[15:0];
        `A_POST_HI: next_post_hi = hwdata[15:0];
        `A_AREA: next_area = hwdata[15:0];
        `A_INT_EN: next_int_en = hwdata[1:0];
        default: begin
          for (int b = 0; b < BOARDS; b++) begin
            if (d_addr == `A_QSEL0 + 32'(4 * b)) begin
              next_qsel_pend[b] = hwdata[15:0];
            end
          end
        end
      endcase
    end
    next_trig_act = trig_act;
    next_qsel_act = qsel_act;
    if (xfer_go) begin
      next_trig_act = trig_pend;
      next_qsel_act = qsel_pend;
    end
    next_state = state;
    next_tick_cnt = tick_cnt;
    next_sample_due = sample_due;
    next_post_left = post_left;
    next_sample_cnt = sample_cnt;
    next_rec_idx = rec_idx;
    next_sys_flag = sys_flag;
    next_host = host_interrupt_lines;
    next_mem_wr_valid = mem_wr_valid && !mem_wr_ready;
    next_mem_wr_addr = mem_wr_addr;
    next_mem_wr_data = mem_wr_data;
    if (state == S_PRE || state == S_POST) begin
      if (tick_cnt >= SAMPLE_CYC - 16'h1) begin
        next_tick_cnt = 16'h0000;
        next_sample_due = 1'b1;
      end else begin
        next_tick_cnt = tick_cnt + 16'h1;
      end
    end
    if (issue) begin
      next_sample_due = 1'b0;
      next_mem_wr_valid = 1'b1;
      next_mem_wr_addr = {rec_idx, 6'h00};
      next_mem_wr_data = '0;
      next_mem_wr_data[BOARDS*BITS-1:0] = in_sync;
      for (int b = 0; b < BOARDS; b++) begin
        next_mem_wr_data[BOARDS*BITS + 32*b +: 32] = qcount[b];
      end
      next_mem_wr_data[BOARDS*BITS + 32*BOARDS +: 32] = sample_cnt;
      next_sample_cnt = sample_cnt + 32'h1;
      next_rec_idx = (rec_idx + 22'h1 == rec_limit) ? 22'h0
        : rec_idx + 22'h1;
      if (state == S_POST) begin
        next_post_left = post_left - 32'h1;
      end
    end
    unique case (state)
      S_IDLE, S_DONE: begin
        if (log_go) begin
          next_state = S_PRE;
          next_tick_cnt = 16'h0000;
          next_sample_due = 1'b0;
          next_sample_cnt = 32'h0;
          next_rec_idx = 22'h0;
          next_sys_flag = 16'h0000;
          next_host[`B_HOST_DONE] = 1'b0;
        end
      end
      S_PRE: begin
        if (trig_take) begin
          next_state = S_POST;
          next_post_left = {post_hi, post_lo};
          int_set[`B_INT_TRIG] = 1'b1;
        end
      end
      S_POST: begin
        if (post_left == 32'h0 && !mem_wr_valid) begin
          next_state = S_DONE;
          next_sys_flag[`B_FLAG_DONE] = 1'b1;
          next_host[`B_HOST_DONE] = 1'b1;
          int_set[`B_INT_DONE] = 1'b1;
        end
      end
    endcase
    if (!sys_run) begin
      next_state = S_IDLE;
      next_sample_due = 1'b0;
    end
    next_int_stat = int_stat;
    if (wr_en && d_addr == `A_INT_CLR) begin
      next_int_stat = int_stat & ~hwdata[1:0];
    end
    next_int_stat = next_int_stat | int_set;
    next_irq = |(next_int_stat & next_int_en);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      d_sel <= 1'b0;
      d_write <= 1'b0;
      d_addr <= 32'h0000_0000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      run_ctrl <= `RST_REG;
      xfer_ctrl <= `RST_REG;
      trig_pend <= `RST_REG;
      trig_act <= `RST_REG;
      trig_sel <= `RST_REG;
      post_lo <= `RST_REG;
      post_hi <= `RST_REG;
      area <= `RST_AREA;
      sys_flag <= `RST_REG;
      for (int b = 0; b < BOARDS; b++) begin
        qsel_pend[b] <= `RST_REG;
        qsel_act[b] <= `RST_REG;
      end
      sys_run <= 1'b0;
      trig_prev <= 1'b0;
      int_stat <= 2'b00;
      int_en <= 2'b00;
      irq <= 1'b0;
      state <= S_IDLE;
      tick_cnt <= 16'h0000;
      sample_due <= 1'b0;
      post_left <= 32'h0;
      sample_cnt <= 32'h0;
      rec_idx <= 22'h0;
      mem_wr_valid <= 1'b0;
      mem_wr_cs <= `CS_LOG;
      mem_wr_addr <= 28'h0;
      mem_wr_data <= '0;
      host_interrupt_lines <= 3'b000;
      base_board_reset_n <= 3'b000;
      ext_board_reset_n <= 1'b0;
      board_output_bits <= '0;
      board_output_clock <= '0;
    end else begin
      d_sel <= next_d_sel;
      d_write <= next_d_write;
      d_addr <= next_d_addr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      run_ctrl <= next_run_ctrl;
      xfer_ctrl <= next_xfer_ctrl;
      trig_pend <= next_trig_pend;
      trig_act <= next_trig_act;
      trig_sel <= next_trig_sel;
      post_lo <= next_post_lo;
      post_hi <= next_post_hi;
      area <= next_area;
      sys_flag <= next_sys_flag;
      qsel_pend <= next_qsel_pend;
      qsel_act <= next_qsel_act;
      sys_run <= next_sys_run;
      trig_prev <= trig_act[`B_USER_TRIG];
      int_stat <= next_int_stat;
      int_en <= next_int_en;
      irq <= next_irq;
      state <= next_state;
      tick_cnt <= next_tick_cnt;
      sample_due <= next_sample_due;
      post_left <= next_post_left;
      sample_cnt <= next_sample_cnt;
      rec_idx <= next_rec_idx;
      mem_wr_valid <= next_mem_wr_valid;
      mem_wr_cs <= `CS_LOG;
      mem_wr_addr <= next_mem_wr_addr;
      mem_wr_data <= next_mem_wr_data;
      host_interrupt_lines <= next_host;
      base_board_reset_n <= {3{next_sys_run}};
      ext_board_reset_n <= next_sys_run;
      board_output_bits <= '0;
      board_output_clock <= '0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_issue;
    issue ##1 mem_wr_valid;
  endsequence
  property p_run_pins;
    wr_en && d_addr == `A_SYS_CTRL ##1 1'b1 |->
      base_board_reset_n == {3{$past(hwdata[`B_RUN])}}
      && ext_board_reset_n == sys_run && board_output_clock == '0;
  endproperty
  a_run_pins: assert property (p_run_pins) else $error("reset pins");
  property p_start;
    log_go |=> state == S_PRE && sample_cnt == 32'h0;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_one_edge;
    trig_act[`B_USER_TRIG] ##1 trig_act[`B_USER_TRIG] |-> !trig_edge;
  endproperty
  a_one_edge: assert property (p_one_edge) else $error("level fired");
  property p_done_int;
    state == S_POST ##1 state == S_DONE |->
      host_interrupt_lines[`B_HOST_DONE] && int_stat[`B_INT_DONE];
  endproperty
  a_done_int: assert property (p_done_int) else $error("no int");
  property p_done_regs;
    state == S_DONE |-> sys_flag == 16'h0004 && state_code(state) == 16'h0500;
  endproperty
  a_done_regs: assert property (p_done_regs) else $error("bad done");
  property p_record;
    s_issue |-> mem_wr_addr[5:0] == 6'h00
      && sample_cnt == $past(sample_cnt) + 32'h1;
  endproperty
  a_record: assert property (p_record) else $error("bad record");
  property p_area;
    mem_wr_valid && area == 16'h0001 |->
      mem_wr_addr <= 28'h000_7FFF && mem_wr_cs == 2'h1;
  endproperty
  a_area: assert property (p_area) else $error("out of area");
  property p_post_load;
    trig_take |=> state == S_POST && post_left == {post_hi, post_lo};
  endproperty
  a_post_load: assert property (p_post_load) else $error("post load");
  property p_src;
    trig_edge && trig_sel != 16'h0015 && state == S_PRE |=> state == S_PRE
      || !sys_run;
  endproperty
  a_src: assert property (p_src) else $error("wrong source");
  property p_pend;
    !xfer_go |=> trig_act == $past(trig_act)
      && qsel_act_flat == $past(qsel_act_flat);
  endproperty
  a_pend: assert property (p_pend) else $error("early apply");
endmodule : triggered_input_logger

// [logic/logger_map.svh]
`ifndef LOGGER_MAP_SVH
`define LOGGER_MAP_SVH
// register byte addresses
`define A_RUN_CTRL 32'h1000_9000
`define A_XFER_CTRL 32'h1000_A000
`define A_TRIG_CTRL 32'h1000_B300
`define A_SYS_CTRL 32'h1000_C000
`define A_TRIG_SEL 32'h1000_C004
`define A_POST_LO 32'h1000_C008
`define A_POST_HI 32'h1000_C00C
`define A_AREA 32'h1000_C010
`define A_STATE 32'h1000_C014
`define A_SYS_FLAG 32'h1000_C018
`define A_CNT_LO 32'h1000_C01C
`define A_CNT_HI 32'h1000_C020
`define A_INT_STAT 32'h1000_C024
`define A_INT_CLR 32'h1000_C028
`define A_INT_EN 32'h1000_C02C
`define A_QSEL0 32'h1000_C040
`define A_QVAL0 32'h1000_C060
// field positions
`define B_LOG_START 0
`define B_XFER 1
`define B_USER_TRIG 1
`define B_RUN 0
`define B_FLAG_DONE 2
`define B_INT_DONE 0
`define B_INT_TRIG 1
`define B_HOST_DONE 2
// values
`define TRIG_SEL_USER 16'h0015
`define RST_AREA 16'h0001
`define RST_REG 16'h0000
`define ST_IDLE 16'h0000
`define ST_PRE 16'h0010
`define ST_POST 16'h0410
`define ST_DONE 16'h0500
`define CS_LOG 2'h1
`define REC_SHIFT 6
`define AREA_REC_SHIFT 9
// timing
`define CLK_NS 8
`define SAMPLE_NS 1000
`define SAMPLE_CYC ((`SAMPLE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// [logic/logger_pkg.sv]
package logger_pkg;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_PRE = 4'b0010,
    S_POST = 4'b0100,
    S_DONE = 4'b1000
  } log_state_t;
  typedef logic [15:0] reg16_t;
endpackage : logger_pkg

// [logic/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pins in, synchronised out
  input wire logic [W-1:0] pin,
  output logic [W-1:0] sync
);
  logic [W-1:0] meta;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= '0;
      sync <= '0;
    end else begin
      meta <= pin;
      sync <= meta;
    end
  end
endmodule : pin_sync

// [logic/quad_counter.sv]
`timescale 1ns/1ps
module quad_counter (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic clear,
  // phases, already synchronised
  input wire logic phase_a,
  input wire logic phase_b,
  // count
  output logic [31:0] count
);
  logic prev_a;
  logic prev_b;
  logic [31:0] next_count;
  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = '0;
    end else if ((phase_a ^ prev_a) != (phase_b ^ prev_b)) begin
      // one phase moved: every edge counts, direction from phase order
      if (phase_a ^ prev_b) begin
        next_count = count + 32'h1;
      end else begin
        next_count = count - 32'h1;
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_a <= 1'b0;
      prev_b <= 1'b0;
      count <= '0;
    end else begin
      prev_a <= phase_a;
      prev_b <= phase_b;
      count <= next_count;
    end
  end
  property p_step;
    @(posedge hclk) disable iff (!hresetn)
    !clear |=> (count - $past(count) <= 32'h1)
      || ($past(count) - count <= 32'h1);
  endproperty
  a_step: assert property (p_step) else $error("count jumped");
endmodule : quad_counter

// [sim/record_sink.sv]
`timescale 1ns/1ps
module record_sink (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // record write port
  input wire logic mem_wr_valid,
  output logic mem_wr_ready,
  input wire logic [1:0] mem_wr_cs,
  input wire logic [27:0] mem_wr_addr,
  input wire logic [511:0] mem_wr_data,
  // tallies
  output int n_rec,
  output int n_bad
);
  logic [1:0] phase;
  logic [27:0] exp_addr;
  // stalls one cycle in four
  assign mem_wr_ready = (phase != 2'h3);
  assign exp_addr = 28'((n_rec * 64) % 32768);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= 2'h0;
      n_rec <= 0;
      n_bad <= 0;
    end else begin
      phase <= phase + 2'h1;
      if (mem_wr_valid && mem_wr_ready) begin
        n_rec <= n_rec + 1;
        if (mem_wr_cs !== 2'h1 || mem_wr_addr !== exp_addr ||
            mem_wr_data[240+:32] !== 32'(n_rec) ||
            mem_wr_data[48+:32] !== 32'h0000_0014 ||
            mem_wr_data[80+:160] !== '0 || mem_wr_data[1:0] !== 2'h0 ||
            mem_wr_data[511:272] !== '0) begin
          n_bad <= n_bad + 1;
        end
      end
    end
  end
endmodule : record_sink

// [sim/triggered_input_logger_test.sv]
`timescale 1ns/1ps
`include "logger_map.svh"
module triggered_input_logger_test;
  import logger_pkg::*;
  localparam int SC = 24;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irq, mem_wr_valid, mem_wr_ready, ext_board_reset_n;
  logic [31:0] hrdata;
  logic [47:0] board_input_bits = 48'h0;
  logic [47:0] board_output_bits;
  logic [5:0] board_output_clock;
  logic [2:0] base_board_reset_n, host_interrupt_lines;
  logic [1:0] mem_wr_cs, quad = 2'h0;
  logic [27:0] mem_wr_addr;
  logic [511:0] mem_wr_data;
  logic [31:0] seed = 32'h68D716DB;
  int n_rec, n_bad, n_fail = 0, check_count = 0, cyc = 0, n;
  triggered_input_logger #(.BOARDS(6), .BITS(8), .SAMPLE_CYC(16'(SC)))
  i_triggered_input_logger (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .board_input_bits(board_input_bits),
    .base_board_reset_n(base_board_reset_n),
    .ext_board_reset_n(ext_board_reset_n),
    .board_output_bits(board_output_bits),
    .board_output_clock(board_output_clock), .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready), .mem_wr_cs(mem_wr_cs),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .host_interrupt_lines(host_interrupt_lines), .irq(irq));
  record_sink i_record_sink (.hclk(hclk), .hresetn(hresetn),
    .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
    .mem_wr_cs(mem_wr_cs), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .n_rec(n_rec), .n_bad(n_bad));
  ////////////////////////////////////////////////////////////////////////
  always #4 hclk = ~hclk;
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  function automatic logic [31:0] exp_total(input int pre, input int post);
    return 32'(pre + post);
  endfunction : exp_total
  // random levels on every pin but the counter phases of board 0
  always @(posedge hclk) begin
    seed <= xorshift(seed);
    board_input_bits <= {seed, seed[15:2], quad};
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      $display("ERROR %0t got %h expected %h", $time, got, exp);
      n_fail = n_fail + 1;
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : ahb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr
  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask : rdchk
  task automatic settle();
    repeat (2) @(posedge hclk);
  endtask : settle
  task automatic tally_and_finish();
    if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    chk({base_board_reset_n, ext_board_reset_n}, 32'h0);
    rdchk(`A_AREA, 32'h0001);
    rdchk(`A_STATE, 32'h0000);
    wr(`A_QSEL0, 32'h0201);
    wr(`A_TRIG_SEL, 32'h0015);
    wr(`A_POST_LO, 32'h0080);
    wr(`A_POST_HI, 32'h0000);
    wr(`A_XFER_CTRL, 32'h0002);
    wr(`A_SYS_CTRL, 32'h0001);
    settle();
    chk({base_board_reset_n, ext_board_reset_n}, 32'hF);
    chk(32'(|{board_output_bits, board_output_clock}), 32'h0);
    for (n = 0; n < 20; n++) begin
      quad <= (n % 4 == 0) ? 2'h1 : (n % 4 == 1) ? 2'h3 :
              (n % 4 == 2) ? 2'h2 : 2'h0;
      repeat (4) @(posedge hclk);
    end
    settle();
    rdchk(`A_QVAL0, 32'd20);
    wr(`A_INT_EN, 32'h0001);
    wr(`A_RUN_CTRL, 32'h0001);
    rdchk(`A_STATE, 32'h0010);
    while (n_rec < 4) @(posedge hclk);
    wr(`A_TRIG_CTRL, 32'h0002);
    rdchk(`A_STATE, 32'h0010);
    wr(`A_XFER_CTRL, 32'h0002);
    wr(`A_TRIG_CTRL, 32'h0000);
    wr(`A_XFER_CTRL, 32'h0002);
    for (n = 0; n < 128 * SC && host_interrupt_lines[2] !== 1'b1; n++)
      @(posedge hclk);
    chk(32'(n < 128 * SC), 32'h1);
    settle();
    chk({29'h0, irq, host_interrupt_lines[1:0]}, 32'h4);
    rdchk(`A_STATE, 32'h0500);
    rdchk(`A_SYS_FLAG, 32'h0004);
    rdchk(`A_CNT_LO, exp_total(4, 128));
    rdchk(`A_CNT_HI, 32'h0000);
    chk(32'(n_rec), exp_total(4, 128));
    chk(32'(n_bad), 32'h0);
    wr(`A_INT_EN, 32'h0000);
    settle();
    chk({31'h0, irq}, 32'h0);
    wr(`A_INT_EN, 32'h0001);
    settle();
    chk({31'h0, irq}, 32'h1);
    wr(`A_INT_CLR, 32'h0003);
    settle();
    chk({31'h0, irq}, 32'h0);
    rdchk(`A_INT_STAT, 32'h0000);
    wr(`A_STATE, 32'hFFFF);
    rdchk(`A_STATE, 32'h0500);
    rdchk(32'h1000_CFF0, 32'h0000);
    rdchk(`A_QVAL0 + 32'h4, 32'h0000);
    wr(`A_TRIG_SEL, 32'h0014);
    wr(`A_RUN_CTRL, 32'h0001);
    wr(`A_TRIG_CTRL, 32'h0002);
    wr(`A_XFER_CTRL, 32'h0002);
    settle();
    rdchk(`A_STATE, 32'h0010);
    wr(`A_TRIG_SEL, 32'h0015);
    settle();
    rdchk(`A_STATE, 32'h0010);
    wr(`A_SYS_CTRL, 32'h0000);
    settle();
    chk({base_board_reset_n, ext_board_reset_n}, 32'h0);
    rdchk(`A_STATE, 32'h0000);
    tally_and_finish();
  end
endmodule : triggered_input_logger_test
